/* File: design/fscg_top.sv */
// Function
// [R1] Select bit 0 runs core clock from slow clock, 1 from divided fast clock.
// [R2] Fast oscillator enable resets to 0 (stopped); 1 starts the oscillator.
// [R3] Lock flag is read-only: 1 when PLL is stable, else 0.
// [R4] Wake-up time register takes writes only while the oscillator is stopped.
// [R5] Software writes zero to reserved wake-up time bits.
// [R6] Wake-up select 0 supplies fast clock after 2.5 ms, 1 after 30 us.
// [R7] Early supply: frequency ramps and is on target within 2 ms.
// [R8] At power-up slow clock is selected and CPU waits 512 slow cycles.
// [R9] After stop release the CPU resumes after 8 slow cycles.
// [R10] PLL runs from slow clock; fast clock appears after a stabilisation count.
// [R11] PLL stops in fast-halt, stop and deep-stop modes; the code has fast-halt and stop only, no deep-stop mode.
// [R12] Fast clock wake-up from stop takes at least 8 slow cycles.
// [R13] Fast clock frequency is fixed at 32, 24 or 16 MHz by option.
// [R14] Fast clock can be routed out to a port pin.
// [R15] Watchdog clock is slow clock divided to 1.024 kHz or its own RC.
// [R16] Watchdog clock stops in stop; returns after one watchdog RC cycle.
// [R17] Software-writable trim register adjusts the slow RC oscillator.
// [R18] While the oscillator is disabled the select bit is forced to 0.
// [R19] Core divider select divides the fast clock by 1, 2, 4, 8, 16 or 32.
//
// The implementer's own choices: the address map and strobed register access.
module fscg_top #(
   parameter int STAB_CYCLES = fscg_pkg::STAB_CYC,
   parameter int RAMP_CYCLES = fscg_pkg::RAMP_CYC
) (
   input wire logic clk, // 40 MHz system clock
   input wire logic rst_n, // asynchronous reset
   input wire logic [fscg_pkg::ADDR_W-1:0] addr, // register address
   input wire logic [fscg_pkg::DATA_W-1:0] wr_data, // write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   output logic [fscg_pkg::DATA_W-1:0] rd_data, // read data, next cycle
   input wire fscg_pkg::fscg_pmode_e power_mode, // requested power mode
   input wire logic [1:0] pll_mode_opt, // PLL frequency option strap
   input wire logic wdt_src_opt, // watchdog source option strap
   input wire logic slow_clock, // slow RC oscillator pin
   input wire logic pll_clock, // raw PLL oscillator output
   input wire logic watchdog_rc_clock, // watchdog RC oscillator
   output logic core_clock, // core clock
   output logic cpu_run, // CPU may execute
   output logic pll_enable, // PLL oscillator run request
   output logic [1:0] pll_freq_sel, // PLL frequency setting
   output logic fast_clock_output, // fast clock to port pin
   output logic watchdog_clock, // watchdog operating clock
   output logic [7:0] slow_rc_trim, // slow RC trim value
   output logic irq // interrupt, level
);
   import fscg_pkg::*;

   // ***************************************************************
   // Reset and synchronisers
   // ***************************************************************
   logic [1:0] rst_sync_q;
   logic rst_sys_n;
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic slow_rise;
   logic fast_rise;
   logic wrc_rise;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_sys_n = rst_sync_q[1];

   // Clocks from outside are only sampled here, so a PLL output close to the
   // 40 MHz rate is reproduced coarsely; edges only count correctly for clocks well below 20 MHz.
   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         pin_s3_q <= 3'h0;
      end else begin
         pin_s1_q <= {watchdog_rc_clock, pll_clock, slow_clock};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   assign slow_rise = pin_s2_q[0] & ~pin_s3_q[0];
   assign fast_rise = pin_s2_q[1] & ~pin_s3_q[1];
   assign wrc_rise = pin_s2_q[2] & ~pin_s3_q[2];

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic sel_q;
   logic en_q;
   logic wake_sel_q;
   logic [7:0] trim_q;
   logic [2:0] core_div_q;
   logic [2:0] out_div_q;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] evt;
   logic lock_q;
   logic ready_q;
   logic wake_evt_q;
   logic lock_dly_q;
   logic ready_dly_q;
   logic wr_ctrl;
   logic wr_isr;

   assign wr_ctrl = wr_en && (addr == ADDR_CTRL);
   assign wr_isr = wr_en && (addr == ADDR_ISTAT);

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         en_q <= 1'b0; // [R2]
         sel_q <= 1'b0;
      end else if (wr_ctrl) begin
         en_q <= wr_data[CTRL_EN_BIT]; // [R2]
         sel_q <= wr_data[CTRL_SEL_BIT] & wr_data[CTRL_EN_BIT]; // [R18]
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         wake_sel_q <= 1'b0;
      end else if (wr_en && addr == ADDR_WUPT && !en_q) begin // [R4]
         wake_sel_q <= wr_data[WUPT_SEL_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         trim_q <= TRIM_RESET;
         core_div_q <= CORE_DIV_RESET;
         out_div_q <= OUT_DIV_RESET;
         mask_q <= '0;
      end else if (wr_en) begin
         if (addr == ADDR_TRIM) begin
            trim_q <= wr_data; // [R17]
         end
         if (addr == ADDR_DIV) begin
            core_div_q <= wr_data[2:0]; // [R19]
            out_div_q <= wr_data[6:4];
         end
         if (addr == ADDR_IMASK) begin
            mask_q <= wr_data[IRQ_W-1:0];
         end
      end
   end

   assign evt = {wake_evt_q, ready_q & ~ready_dly_q, lock_q & ~lock_dly_q};

   // A new event in the cycle of its clearing write stays set.
   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         stat_q <= '0;
         lock_dly_q <= 1'b0;
         ready_dly_q <= 1'b0;
         irq <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~(wr_isr ? wr_data[IRQ_W-1:0] : '0)) | evt;
         lock_dly_q <= lock_q;
         ready_dly_q <= ready_q;
         irq <= |(stat_q & mask_q);
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         rd_data <= '0;
      end else if (!rd_en) begin
         rd_data <= '0;
      end else begin
         unique case (addr)
            ADDR_CTRL: rd_data <= {lock_q, 5'h00, en_q, sel_q}; // [R3]
            ADDR_WUPT: rd_data <= {7'h00, wake_sel_q};
            ADDR_TRIM: rd_data <= trim_q;
            ADDR_DIV: rd_data <= {1'b0, out_div_q, 1'b0, core_div_q};
            ADDR_ISTAT: rd_data <= {5'h00, stat_q};
            ADDR_IMASK: rd_data <= {5'h00, mask_q};
            default: rd_data <= '0;
         endcase
      end
   end

   // ***************************************************************
   // Option straps
   // ***************************************************************
   logic opt_done_q;
   logic wdt_src_q;

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         opt_done_q <= 1'b0;
         pll_freq_sel <= 2'b00;
         wdt_src_q <= 1'b0;
      end else if (!opt_done_q) begin
         opt_done_q <= 1'b1;
         pll_freq_sel <= pll_mode_opt; // [R13]
         wdt_src_q <= wdt_src_opt; // [R15]
      end
   end

   // ***************************************************************
   // Power sequencing
   // ***************************************************************
   fscg_state_e state_q;
   logic [SLOW_CNT_W-1:0] slow_cnt_q;

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         state_q <= FSCG_ST_BOOT;
         slow_cnt_q <= '0;
         wake_evt_q <= 1'b0;
      end else begin
         wake_evt_q <= 1'b0;
         unique case (state_q)
            FSCG_ST_BOOT: begin
               if (slow_rise) begin
                  if (slow_cnt_q == SLOW_CNT_W'(BOOT_SLOW_CNT - 1)) begin // [R8]
                     state_q <= FSCG_ST_RUN;
                     slow_cnt_q <= '0;
                  end else begin
                     slow_cnt_q <= slow_cnt_q + 1'b1;
                  end
               end
            end
            FSCG_ST_RUN: begin
               if (power_mode == FSCG_PM_STOP) begin
                  state_q <= FSCG_ST_STOP;
               end
            end
            FSCG_ST_STOP: begin
               if (power_mode != FSCG_PM_STOP) begin
                  state_q <= FSCG_ST_RESUME;
                  slow_cnt_q <= '0;
               end
            end
            FSCG_ST_RESUME: begin
               if (slow_rise) begin
                  if (slow_cnt_q == SLOW_CNT_W'(RESUME_SLOW_CNT - 1)) begin // [R9]
                     state_q <= FSCG_ST_RUN;
                     slow_cnt_q <= '0;
                     wake_evt_q <= 1'b1;
                  end else begin
                     slow_cnt_q <= slow_cnt_q + 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         cpu_run <= 1'b0;
      end else begin
         cpu_run <= (state_q == FSCG_ST_RUN);
      end
   end

   // ***************************************************************
   // PLL control
   // ***************************************************************
   logic [STAB_CNT_W-1:0] stab_cnt_q;

   // The PLL only restarts once the resume count has run, so a fast
   // wake-up from stop can never beat the slow-clock count.
   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         pll_enable <= 1'b0;
      end else begin
         pll_enable <= en_q && state_q == FSCG_ST_RUN // [R12]
            && power_mode != FSCG_PM_FHALT && power_mode != FSCG_PM_STOP; // [R11]
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         stab_cnt_q <= '0;
      end else if (!pll_enable) begin
         stab_cnt_q <= '0;
      end else if (stab_cnt_q != '1) begin
         stab_cnt_q <= stab_cnt_q + 1'b1; // [R10]
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         lock_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         lock_q <= pll_enable && stab_cnt_q >= (wake_sel_q ? // [R3] [R7]
            STAB_CNT_W'(RAMP_CYCLES) : STAB_CNT_W'(STAB_CYCLES));
         ready_q <= pll_enable && stab_cnt_q >= (wake_sel_q ? // [R6]
            STAB_CNT_W'(EARLY_CYC) : STAB_CNT_W'(STAB_CYCLES));
      end
   end

   // ***************************************************************
   // Clock outputs
   // ***************************************************************
   logic [FDIV_W-1:0] fdiv_q;
   logic [WDT_DIV_W-1:0] wdiv_q;
   logic wdt_on_q;

   function automatic logic div_pick(input logic [2:0] code, input logic [FDIV_W-1:0] cnt,
                                     input logic lvl);
      unique case (code)
         3'h0: div_pick = lvl;
         3'h1: div_pick = cnt[0];
         3'h2: div_pick = cnt[1];
         3'h3: div_pick = cnt[2];
         3'h4: div_pick = cnt[3];
         default: div_pick = cnt[4];
      endcase
   endfunction : div_pick

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         fdiv_q <= '0;
         wdiv_q <= '0;
      end else begin
         if (fast_rise && ready_q) begin
            fdiv_q <= fdiv_q + 1'b1;
         end
         if (slow_rise) begin
            wdiv_q <= wdiv_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         core_clock <= 1'b0;
         fast_clock_output <= 1'b0;
      end else begin
         core_clock <= (sel_q && ready_q) ? // [R1]
            div_pick(core_div_q, fdiv_q, pin_s2_q[1]) : pin_s2_q[0]; // [R19]
         fast_clock_output <= ready_q && out_div_q != 3'h0 && out_div_q <= 3'h5 // [R14]
            && div_pick(out_div_q, fdiv_q, pin_s2_q[1]);
      end
   end

   always_ff @(posedge clk or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         wdt_on_q <= 1'b0;
         watchdog_clock <= 1'b0;
      end else begin
         if (state_q == FSCG_ST_STOP) begin
            wdt_on_q <= 1'b0; // [R16]
         end else if (wrc_rise) begin
            wdt_on_q <= 1'b1; // [R16]
         end
         watchdog_clock <= wdt_on_q && state_q != FSCG_ST_STOP
            && (wdt_src_q ? pin_s2_q[2] : wdiv_q[WDT_DIV_W-1]); // [R15]
      end
   end

   assign slow_rc_trim = trim_q;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sel_forced_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R18]
      !en_q |-> !sel_q) else $error("select set while oscillator off");
   lock_cause_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R3]
      lock_q |-> $past(pll_enable)) else $error("lock without running PLL");
   wupt_hold_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R4]
      en_q |=> $stable(wake_sel_q)) else $error("wake-up time changed while running");
   boot_hold_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R8]
      (state_q == FSCG_ST_BOOT) |=> !cpu_run) else $error("CPU ran during boot");
   resume_hold_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R9]
      (state_q == FSCG_ST_STOP && power_mode != FSCG_PM_STOP) |=> !cpu_run [*8])
      else $error("CPU resumed too early");
   pll_halt_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R11]
      (power_mode == FSCG_PM_FHALT || power_mode == FSCG_PM_STOP) |=> !pll_enable)
      else $error("PLL left running in low-power mode");
   early_ready_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R6]
      (pll_enable && wake_sel_q && stab_cnt_q == STAB_CNT_W'(EARLY_CYC)) |=> ready_q)
      else $error("early supply missed");
   core_slow_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R1]
      !(sel_q && ready_q) |=> core_clock == $past(pin_s2_q[0]))
      else $error("core clock not from slow clock");
   wdt_stop_a: assert property (@(posedge clk) disable iff (!rst_sys_n) // [R16]
      (state_q == FSCG_ST_STOP) |=> !watchdog_clock) else $error("watchdog clock in stop");
   irq_level_a: assert property (@(posedge clk) disable iff (!rst_sys_n)
      ##1 irq == |($past(stat_q) & $past(mask_q))) else $error("interrupt level wrong");
endmodule : fscg_top

/* File: design/fscg_pkg.sv */
package fscg_pkg;
   // ***************************************************************
   // Register map and fields
   // ***************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_WUPT = 4'h1;
   localparam logic [3:0] ADDR_TRIM = 4'h2;
   localparam logic [3:0] ADDR_DIV = 4'h3;
   localparam logic [3:0] ADDR_ISTAT = 4'h4;
   localparam logic [3:0] ADDR_IMASK = 4'h5;
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_EN_BIT = 1;
   localparam int CTRL_LOCK_BIT = 7;
   localparam int WUPT_SEL_BIT = 0;
   localparam logic [2:0] CORE_DIV_RESET = 3'h4;
   localparam logic [2:0] OUT_DIV_RESET = 3'h4;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_READY = 1;
   localparam int IRQ_WAKE = 2;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int STAB_TIME_US = 2500;
   localparam int EARLY_TIME_US = 30;
   localparam int RAMP_TIME_US = 2000;
   localparam int STAB_CYC = STAB_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int EARLY_CYC = EARLY_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int RAMP_CYC = RAMP_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int STAB_CNT_W = 20;
   localparam int BOOT_SLOW_CNT = 512;
   localparam int RESUME_SLOW_CNT = 8;
   localparam int SLOW_CNT_W = 10;
   localparam int WDT_DIV_W = 5;
   localparam int FDIV_W = 5;
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      FSCG_PM_RUN = 2'b00,
      FSCG_PM_HALT = 2'b01,
      FSCG_PM_FHALT = 2'b10,
      FSCG_PM_STOP = 2'b11
   } fscg_pmode_e;
   typedef enum logic [1:0] {
      FSCG_ST_BOOT = 2'b00,
      FSCG_ST_RUN = 2'b01,
      FSCG_ST_STOP = 2'b10,
      FSCG_ST_RESUME = 2'b11
   } fscg_state_e;
endpackage : fscg_pkg

/* File: test/fscg_tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fscg_pkg::*;
   localparam int LIMIT = 40000;
   localparam int WIN = 960;
   localparam logic [7:0] LCK = 8'h01 << IRQ_LOCK;
   localparam logic [7:0] RDY = 8'h01 << IRQ_READY;
   localparam logic [7:0] WAK = 8'h01 << IRQ_WAKE;
   logic clk, rst_n, wr_en, rd_en, wdt_src_opt;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data, rd_data;
   fscg_pmode_e power_mode;
   logic [1:0] pll_mode_opt, pll_freq_sel;
   logic slow_clock, pll_clock, watchdog_rc_clock;
   logic core_clock, cpu_run, pll_enable, fast_clock_output, watchdog_clock, irq;
   logic [7:0] slow_rc_trim;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   int n_core = 0;
   int n_fout = 0;
   int n_wdog = 0;
   int t0, w, dc, df, dw, oc, cd;

   fscg_top #(.STAB_CYCLES(2000), .RAMP_CYCLES(1500)) dut_u (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .power_mode(power_mode),
      .pll_mode_opt(pll_mode_opt), .wdt_src_opt(wdt_src_opt), .slow_clock(slow_clock),
      .pll_clock(pll_clock), .watchdog_rc_clock(watchdog_rc_clock),
      .core_clock(core_clock), .cpu_run(cpu_run), .pll_enable(pll_enable),
      .pll_freq_sel(pll_freq_sel), .fast_clock_output(fast_clock_output),
      .watchdog_clock(watchdog_clock), .slow_rc_trim(slow_rc_trim), .irq(irq)
   );

   // ***************************************************************
   // Clocks and edge counters
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // The oscillator pins run much faster than the real parts so that boot fits the run.
   initial begin
      slow_clock = 1'b0;
      forever #100 slow_clock = ~slow_clock;
   end
   initial begin
      watchdog_rc_clock = 1'b0;
      forever #125 watchdog_rc_clock = ~watchdog_rc_clock;
   end
   // The raw oscillator idles low whenever the block does not ask it to run.
   initial begin
      pll_clock = 1'b0;
      forever #75 pll_clock = (pll_enable === 1'b1) ? ~pll_clock : 1'b0;
   end
   always @(posedge core_clock) n_core++;
   always @(posedge fast_clock_output) n_fout++;
   always @(posedge watchdog_clock) n_wdog++;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         close_out();
      end
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic close_out();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic in_range(input string what, input int seen, input int lo, input int hi);
      check(what, 16'(seen >= lo && seen <= hi), 16'h0001);
   endtask : in_range

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rchk(input string what, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      check(what, 16'(rd_data), 16'(exp));
   endtask : rchk

   // Counts clock edges over a window after letting a divider change settle.
   task automatic measure(input int n);
      int a, b, c;
      repeat (40) @(posedge clk);
      a = n_core;
      b = n_fout;
      c = n_wdog;
      repeat (n) @(posedge clk);
      dc = n_core - a;
      df = n_fout - b;
      dw = n_wdog - c;
   endtask : measure

   task automatic wait_to(input int t);
      while (cyc - t0 < t) @(posedge clk);
   endtask : wait_to

   task automatic boot();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      w = 0;
      while (cpu_run !== 1'b1 && w < 6000) begin
         @(posedge clk);
         w++;
      end
   endtask : boot

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      rst_n = 1'b0;
      addr = '0;
      wr_data = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      power_mode = FSCG_PM_RUN;
      pll_mode_opt = 2'b01;
      wdt_src_opt = 1'b0;
      boot();
      in_range("boot wait", w, 4080, 4140);
      check("freq strap", 16'(pll_freq_sel), 16'h0001);
      measure(WIN);
      in_range("slow core", dc, 118, 122);
      wr(ADDR_CTRL, 8'h81);
      rchk("ctrl off", ADDR_CTRL, 8'h00);
      wr(ADDR_WUPT, 8'h01);
      rchk("wupt early", ADDR_WUPT, 8'h01);
      wr(ADDR_CTRL, 8'h02);
      t0 = cyc;
      repeat (2) @(posedge clk);
      #1 check("pll on", 16'(pll_enable), 16'h0001);
      wr(ADDR_WUPT, 8'h00);
      rchk("wupt held", ADDR_WUPT, 8'h01);
      wait_to(1100);
      rchk("early wait", ADDR_ISTAT, 8'h00);
      wait_to(1300);
      rchk("early ready", ADDR_ISTAT, RDY);
      wait_to(1600);
      rchk("ramp lock", ADDR_ISTAT, RDY | LCK);
      rchk("ctrl lock", ADDR_CTRL, 8'h82);
      wr(ADDR_CTRL, 8'h03);
      rchk("ctrl sel", ADDR_CTRL, 8'h83);
      // Eight codes on the core divider; the output divider walks its legal codes alongside.
      for (int c = 0; c < 8; c++) begin
         oc = (c >= 1 && c <= 5) ? c : 4;
         cd = (c > 5) ? 5 : c;
         wr(ADDR_DIV, 8'(oc * 16 + c));
         measure(WIN);
         in_range("core div", dc, (160 >> cd) - 2, (160 >> cd) + 2);
         in_range("out div", df, (160 >> oc) - 2, (160 >> oc) + 2);
      end
      wr(ADDR_CTRL, 8'h02);
      measure(2 * WIN);
      in_range("slow again", dc, 237, 243);
      in_range("wdog slow", dw, 6, 9);
      @(posedge clk);
      power_mode <= FSCG_PM_FHALT;
      repeat (2) @(posedge clk);
      #1 check("fhalt pll", 16'(pll_enable), 16'h0000);
      @(posedge clk);
      power_mode <= FSCG_PM_RUN;
      repeat (10) @(posedge clk);
      power_mode <= FSCG_PM_STOP;
      repeat (20) @(posedge clk);
      #1 check("stop pll", 16'(pll_enable), 16'h0000);
      check("stop cpu", 16'(cpu_run), 16'h0000);
      measure(600);
      check("wdog stop", 16'(dw), 16'h0000);
      @(posedge clk);
      power_mode <= FSCG_PM_RUN;
      w = 0;
      while (cpu_run !== 1'b1 && w < 500) begin
         @(posedge clk);
         w++;
      end
      in_range("resume", w, 56, 80);
      rchk("wake stat", ADDR_ISTAT, WAK | RDY | LCK);
      measure(600);
      in_range("wdog back", dw, 1, 4);
      pll_mode_opt <= 2'b10;
      wdt_src_opt <= 1'b1;
      boot();
      in_range("reboot wait", w, 4080, 4140);
      check("freq strap2", 16'(pll_freq_sel), 16'h0002);
      rchk("rst ctrl", ADDR_CTRL, 8'h00);
      rchk("rst wupt", ADDR_WUPT, 8'h00);
      rchk("rst trim", ADDR_TRIM, TRIM_RESET);
      rchk("rst div", ADDR_DIV, {1'b0, OUT_DIV_RESET, 1'b0, CORE_DIV_RESET});
      rchk("rst stat", ADDR_ISTAT, 8'h00);
      rchk("rst mask", ADDR_IMASK, 8'h00);
      wr(ADDR_TRIM, 8'ha5);
      rchk("trim", ADDR_TRIM, 8'ha5);
      check("trim pin", 16'(slow_rc_trim), 16'h00a5);
      wr(4'hf, 8'hff);
      rchk("unmapped", 4'hf, 8'h00);
      wr(ADDR_CTRL, 8'h02);
      t0 = cyc;
      wait_to(1900);
      rchk("stab wait", ADDR_ISTAT, 8'h00);
      wait_to(2100);
      rchk("stab done", ADDR_ISTAT, RDY | LCK);
      measure(2 * WIN);
      in_range("wdog rc", dw, 189, 195);
      check("irq masked", 16'(irq), 16'h0000);
      wr(ADDR_IMASK, RDY);
      repeat (3) @(posedge clk);
      #1 check("irq on", 16'(irq), 16'h0001);
      wr(ADDR_ISTAT, RDY);
      rchk("w1c", ADDR_ISTAT, LCK);
      repeat (3) @(posedge clk);
      #1 check("irq off", 16'(irq), 16'h0000);
      close_out();
   end
endmodule : tb
